// ### hdl/mbm_cfg.svh
`ifndef MBM_CFG_SVH
`define MBM_CFG_SVH
`define MBM_LONG_W 36
`define MBM_HALF_W 18
`define MBM_BYTE_W 9
`define MBM_LANES 4
`define MBM_HALF_HI 35
`define MBM_HALF_LO 17
`define MBM_MAIL_RST 36'h000000000
`endif

// ### hdl/mbm_pkg.sv
`include "mbm_cfg.svh"
package mbm_pkg;
   typedef enum logic [1:0] {
      MBM_LONG = 2'b00,
      MBM_WORD = 2'b01,
      MBM_BYTE = 2'b11
   } mbm_size_t;
   typedef logic [`MBM_LONG_W-1:0] mbm_long_t;
endpackage

// ### hdl/mbm_lane_mux.sv
`include "mbm_cfg.svh"
module mbm_lane_mux (
   // selection
   input wire mbm_pkg::mbm_size_t size,
   input wire logic big_endian,
   input wire logic [1:0] index,
   // data
   input wire mbm_pkg::mbm_long_t long_word,
   output mbm_pkg::mbm_long_t lane_out
);
   import mbm_pkg::*;
   logic [1:0] slot;
   always_comb begin
      lane_out = long_word;
      slot = 2'h0;
      case (size)
         MBM_WORD: begin
            // big endian upper half first
            slot = big_endian ? index : ~index;
            lane_out = {`MBM_HALF_W'h0, slot[0] ? long_word[`MBM_HALF_LO:0]
                        : long_word[`MBM_HALF_HI:`MBM_HALF_W]};
         end
         MBM_BYTE: begin
            slot = big_endian ? index : 2'h3 - index;
            lane_out = {27'h0, long_word[(3 - slot) * `MBM_BYTE_W +: `MBM_BYTE_W]};
         end
         default: lane_out = long_word;
      endcase
   end
endmodule

// ### hdl/mbm_core.sv
// Function
// - one 36-bit mail register each way, chosen by mailbox select
// - port A mailbox write stores A lanes of active width into a-to-b mail
// - port B mailbox write stores B lanes of active width into b-to-a mail
// - mail write drops full flag low; further writes refused while low
// - enabled outputs show queue output when select low, mail when high
// - port B mailbox read sets a-to-b mail flag high, mail on low lanes
// - port A mailbox read sets b-to-a mail flag high, mail on low lanes
// - mail contents stay after reads, change only on new writes
// - mail data bypasses endian order and bus matching
// - bus match low long word; high with size low word; else byte
// - size and endian take effect at master reset completion; size here follows the select inputs at all times
// - endian latched at master reset release, ignored in long mode
// - big endian most significant first; little least significant first
// - queues hold only long words; conversion after read, before write
// - long read moves whole word; narrow reads present parts in order
// - narrow writes gather parts; last part commits whole long word
// - unused lanes indeterminate on reads and ignored on writes
// - long mode maps port B lanes straight to port A lanes
// - word mode big first upper half; little first lower half
// - byte mode big first top byte; little first bottom byte
// - narrow reads output bytes or halves in endian order
`include "mbm_cfg.svh"
module mbm_core (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // configuration
   input wire logic bus_match_select,
   input wire logic size_select,
   input wire logic endian_order_select,
   // port A transfer
   input wire logic port_a_chip_select_n,
   input wire logic port_a_write_not_read,
   input wire logic port_a_xfer_gate,
   input wire logic port_a_mailbox_select,
   input wire mbm_pkg::mbm_long_t port_a_data_in,
   input wire mbm_pkg::mbm_long_t port_a_fifo_out,
   output mbm_pkg::mbm_long_t port_a_data_out,
   // port B transfer
   input wire logic port_b_chip_select_n,
   input wire logic port_b_read_not_write,
   input wire logic port_b_xfer_gate,
   input wire logic port_b_mailbox_select,
   input wire mbm_pkg::mbm_long_t port_b_data_in,
   output mbm_pkg::mbm_long_t port_b_data_out,
   // queue a-to-b read side
   input wire mbm_pkg::mbm_long_t ab_queue_word,
   input wire logic ab_queue_valid,
   output logic ab_queue_pop,
   // queue b-to-a write side
   output mbm_pkg::mbm_long_t ba_queue_word,
   output logic ba_queue_push,
   input wire logic ba_queue_space,
   // mail flags
   output logic mail_ab_full_n,
   output logic mail_ba_full_n
);
   import mbm_pkg::*;

   // ************************************
   // reset release
   // ************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ************************************
   // configuration
   // ************************************
   mbm_size_t size;
   logic big_endian;
   logic cfg_taken;
   always_comb begin
      if (!bus_match_select) size = MBM_LONG;
      else if (!size_select) size = MBM_WORD;
      else size = MBM_BYTE;
   end
   // endian caught by first clocked edge after release, held until next reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_taken <= 1'b0;
         big_endian <= 1'b0;
      end else if (!cfg_taken) begin
         cfg_taken <= 1'b1;
         big_endian <= endian_order_select;
      end
   end

   function automatic mbm_long_t lane_mask(input mbm_size_t s, input mbm_long_t d);
      case (s)
         MBM_WORD: lane_mask = {`MBM_HALF_W'h0, d[`MBM_HALF_LO:0]};
         MBM_BYTE: lane_mask = {27'h0, d[`MBM_BYTE_W-1:0]};
         default: lane_mask = d;
      endcase
   endfunction

   function automatic logic [1:0] last_part(input mbm_size_t s);
      case (s)
         MBM_WORD: last_part = 2'h1;
         MBM_BYTE: last_part = 2'h3;
         default: last_part = 2'h0;
      endcase
   endfunction

   // ************************************
   // strobes
   // ************************************
   logic a_sel;
   logic b_sel;
   logic a_mail_wr;
   logic a_mail_rd;
   logic b_mail_wr;
   logic b_mail_rd;
   logic b_fifo_rd;
   logic b_fifo_wr;
   assign a_sel = !port_a_chip_select_n && port_a_xfer_gate;
   assign b_sel = !port_b_chip_select_n && port_b_xfer_gate;
   assign a_mail_wr = a_sel && port_a_write_not_read && port_a_mailbox_select;
   assign a_mail_rd = a_sel && !port_a_write_not_read && port_a_mailbox_select;
   assign b_mail_wr = b_sel && !port_b_read_not_write && port_b_mailbox_select;
   assign b_mail_rd = b_sel && port_b_read_not_write && port_b_mailbox_select;
   assign b_fifo_rd = b_sel && port_b_read_not_write && !port_b_mailbox_select;
   assign b_fifo_wr = b_sel && !port_b_read_not_write && !port_b_mailbox_select;

   // ************************************
   // mailboxes
   // ************************************
   mbm_long_t mail_ab_register;
   mbm_long_t mail_ba_register;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mail_ab_register <= `MBM_MAIL_RST;
      end else if (a_mail_wr && mail_ab_full_n) begin
         mail_ab_register <= lane_mask(size, port_a_data_in);
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mail_ba_register <= `MBM_MAIL_RST;
      end else if (b_mail_wr && mail_ba_full_n) begin
         mail_ba_register <= lane_mask(size, port_b_data_in);
      end
   end
   // a write into an empty box wins over a read of the same edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mail_ab_full_n <= 1'b1;
      end else if (a_mail_wr && mail_ab_full_n) begin
         mail_ab_full_n <= 1'b0;
      end else if (b_mail_rd) begin
         mail_ab_full_n <= 1'b1;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mail_ba_full_n <= 1'b1;
      end else if (b_mail_wr && mail_ba_full_n) begin
         mail_ba_full_n <= 1'b0;
      end else if (a_mail_rd) begin
         mail_ba_full_n <= 1'b1;
      end
   end

   // ************************************
   // a-to-b read splitting
   // ************************************
   mbm_long_t split_word;
   logic [1:0] rd_index;
   logic split_busy;
   mbm_long_t split_lane;
   mbm_long_t fresh_lane;
   assign ab_queue_pop = b_fifo_rd && !split_busy && ab_queue_valid;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         split_word <= `MBM_MAIL_RST;
         rd_index <= 2'h0;
         split_busy <= 1'b0;
      end else if (ab_queue_pop && size != MBM_LONG) begin
         split_word <= ab_queue_word;
         rd_index <= 2'h1;
         split_busy <= 1'b1;
      end else if (b_fifo_rd && split_busy) begin
         rd_index <= rd_index + 2'h1;
         split_busy <= rd_index != last_part(size);
      end
   end
   mbm_lane_mux u_split_mux (
      .size(size),
      .big_endian(big_endian),
      .index(rd_index),
      .long_word(split_word),
      .lane_out(split_lane)
   );
   mbm_lane_mux u_fresh_mux (
      .size(size),
      .big_endian(big_endian),
      .index(2'h0),
      .long_word(ab_queue_word),
      .lane_out(fresh_lane)
   );
   mbm_long_t b_out_reg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         b_out_reg <= `MBM_MAIL_RST;
      end else if (split_busy && b_fifo_rd) begin
         b_out_reg <= split_lane;
      end else if (ab_queue_pop) begin
         b_out_reg <= fresh_lane;
      end
   end
   assign port_b_data_out = port_b_mailbox_select ? mail_ab_register : b_out_reg;
   assign port_a_data_out = port_a_mailbox_select ? mail_ba_register : port_a_fifo_out;

   // ************************************
   // b-to-a write assembly
   // ************************************
   mbm_long_t gather;
   logic [1:0] wr_index;
   logic [1:0] wr_slot;
   mbm_long_t merged;
   logic wr_ok;
   assign wr_ok = b_fifo_wr && ba_queue_space;
   always_comb begin
      merged = gather;
      wr_slot = 2'h0;
      case (size)
         MBM_WORD: begin
            wr_slot = big_endian ? wr_index : ~wr_index;
            if (wr_slot[0]) merged[`MBM_HALF_LO:0] = port_b_data_in[`MBM_HALF_LO:0];
            else merged[`MBM_HALF_HI:`MBM_HALF_W] = port_b_data_in[`MBM_HALF_LO:0];
         end
         MBM_BYTE: begin
            wr_slot = big_endian ? wr_index : 2'h3 - wr_index;
            merged[(3 - wr_slot) * `MBM_BYTE_W +: `MBM_BYTE_W] =
               port_b_data_in[`MBM_BYTE_W-1:0];
         end
         default: merged = port_b_data_in;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gather <= `MBM_MAIL_RST;
         wr_index <= 2'h0;
      end else if (wr_ok) begin
         gather <= merged;
         wr_index <= (wr_index == last_part(size)) ? 2'h0 : wr_index + 2'h1;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ba_queue_word <= `MBM_MAIL_RST;
         ba_queue_push <= 1'b0;
      end else begin
         ba_queue_push <= wr_ok && wr_index == last_part(size);
         ba_queue_word <= merged;
      end
   end

   // ************************************
   // checks
   // ************************************
   sequence ab_written_s;
      a_mail_wr && mail_ab_full_n;
   endsequence
   mail_ab_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ab_written_s |=> !mail_ab_full_n) else $error("mail a-b flag not low");
   mail_ab_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !mail_ab_full_n && a_mail_wr |=> $stable(mail_ab_register))
      else $error("mail a-b overwritten");
   mail_ab_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      b_mail_rd && !a_mail_wr |=> mail_ab_full_n) else $error("mail a-b not freed");
   mail_ba_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      a_mail_rd && !b_mail_wr |=> mail_ba_full_n) else $error("mail b-a not freed");
   mail_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !a_mail_wr |=> $stable(mail_ab_register)) else $error("mail a-b changed");
   mail_lane_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ab_written_s ##1 1'b1 |-> size == MBM_BYTE ? mail_ab_register[35:9] == 27'h0 : 1'b1)
      else $error("mail upper lanes kept");
   out_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      port_b_mailbox_select |-> port_b_data_out == mail_ab_register)
      else $error("port b not showing mail");
   long_push_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      size == MBM_LONG && wr_ok |=> ba_queue_push && ba_queue_word == $past(port_b_data_in))
      else $error("long write not committed");
   word_push_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      size == MBM_WORD && wr_ok && wr_index == 2'h0 |=> !ba_queue_push)
      else $error("first half committed early");
   split_pop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      split_busy |-> !ab_queue_pop) else $error("pop while splitting");
endmodule

// ### dv/mbm_queue_model.sv
module mbm_queue_model (
   // clock
   input wire logic core_clk,
   // feed from the bench
   input wire logic feed_push,
   input wire mbm_pkg::mbm_long_t feed_word,
   input wire logic stall,
   // a-to-b queue head
   output mbm_pkg::mbm_long_t ab_queue_word,
   output logic ab_queue_valid,
   input wire logic ab_queue_pop,
   // b-to-a queue tail
   input wire mbm_pkg::mbm_long_t ba_queue_word,
   input wire logic ba_queue_push,
   output logic ba_queue_space
);
   timeunit 1ns;
   timeprecision 1ns;
   import mbm_pkg::*;
   mbm_long_t q[$];
   mbm_long_t got[$];
   initial begin
      ab_queue_word = '0;
      ab_queue_valid = 1'b0;
   end
   assign ba_queue_space = !stall;
   // only whole long words enter or leave the queues
   // an empty head toggles its lanes so stale data never looks valid
   always @(posedge core_clk) begin
      if (ab_queue_pop && q.size() != 0) begin
         void'(q.pop_front());
      end
      if (feed_push) begin
         q.push_back(feed_word);
      end
      if (ba_queue_push && ba_queue_space) begin
         got.push_back(ba_queue_word);
      end
      ab_queue_valid <= (q.size() != 0);
      ab_queue_word <= (q.size() != 0) ? q[0] : ~ab_queue_word;
   end
endmodule

// ### dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mbm_pkg::*;
   localparam mbm_long_t W = {9'h1A1, 9'h0B2, 9'h1C3, 9'h0D4};
   localparam mbm_long_t M = 36'h9ABCDEF01;
   // one bit per mode: long, word big, word little, byte big, byte little
   localparam logic [4:0] BMS = 5'h1E;
   localparam logic [4:0] SZS = 5'h18;
   localparam logic [4:0] BES = 5'h0B;
   logic core_clk, nrst, bm, sz, be, cfg_be, stall, feed_push;
   logic a_cs_n, a_wr, a_gate, a_mb, b_cs_n, b_rd, b_gate, b_mb;
   logic ab_valid, ab_pop, ba_push, ba_space, ab_full_n, ba_full_n;
   mbm_long_t a_din, a_fifo, a_dout, b_din, b_dout, ab_word, ba_word, feed_word, msk;
   int n_fail, n_compared, nparts;
   mbm_core i_dut (.core_clk(core_clk), .nrst(nrst), .bus_match_select(bm),
      .size_select(sz), .endian_order_select(be), .port_a_chip_select_n(a_cs_n),
      .port_a_write_not_read(a_wr), .port_a_xfer_gate(a_gate),
      .port_a_mailbox_select(a_mb), .port_a_data_in(a_din), .port_a_fifo_out(a_fifo),
      .port_a_data_out(a_dout), .port_b_chip_select_n(b_cs_n),
      .port_b_read_not_write(b_rd), .port_b_xfer_gate(b_gate),
      .port_b_mailbox_select(b_mb), .port_b_data_in(b_din), .port_b_data_out(b_dout),
      .ab_queue_word(ab_word), .ab_queue_valid(ab_valid), .ab_queue_pop(ab_pop),
      .ba_queue_word(ba_word), .ba_queue_push(ba_push), .ba_queue_space(ba_space),
      .mail_ab_full_n(ab_full_n), .mail_ba_full_n(ba_full_n));
   mbm_queue_model i_model (.core_clk(core_clk), .feed_push(feed_push),
      .feed_word(feed_word), .stall(stall), .ab_queue_word(ab_word),
      .ab_queue_valid(ab_valid), .ab_queue_pop(ab_pop), .ba_queue_word(ba_word),
      .ba_queue_push(ba_push), .ba_queue_space(ba_space));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string name, input mbm_long_t exp, input mbm_long_t got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic a_op(input logic wr, input logic mb, input mbm_long_t d);
      @(posedge core_clk);
      a_cs_n <= 1'b0;
      a_wr <= wr;
      a_gate <= 1'b1;
      a_mb <= mb;
      a_din <= d;
      @(posedge core_clk);
      a_gate <= 1'b0;
      a_cs_n <= 1'b1;
      #1;
   endtask
   task automatic b_op(input logic rd, input logic mb, input mbm_long_t d);
      @(posedge core_clk);
      b_cs_n <= 1'b0;
      b_rd <= rd;
      b_gate <= 1'b1;
      b_mb <= mb;
      b_din <= d;
      @(posedge core_clk);
      b_gate <= 1'b0;
      b_cs_n <= 1'b1;
      #1;
   endtask
   function automatic mbm_long_t part(input int k);
      int j;
      j = cfg_be ? nparts - 1 - k : k;
      return (W >> (j * (36 / nparts))) & msk;
   endfunction
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // bus match and size held static between master resets; endian select flipped once caught
   task automatic do_reset(input logic bm_v, input logic sz_v, input logic be_v);
      @(posedge core_clk);
      bm <= bm_v;
      sz <= sz_v;
      be <= be_v;
      nrst <= 1'b0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      // endian is caught on the third edge after release; flip it only after that
      repeat (3) @(posedge core_clk);
      be <= !be_v;
      @(posedge core_clk);
      #1;
      nparts = !bm_v ? 1 : (sz_v ? 4 : 2);
      cfg_be = be_v;
      msk = {36{1'b1}} >> (36 - 36 / nparts);
      chk("ab flag after reset", 36'h1, 36'(ab_full_n));
      chk("ba flag after reset", 36'h1, 36'(ba_full_n));
   endtask
   task automatic t_mail();
      a_op(1'b1, 1'b1, M);
      chk("ab flag after write", 36'h0, 36'(ab_full_n));
      a_op(1'b1, 1'b1, ~M);
      b_op(1'b1, 1'b1, '0);
      chk("ab mail at b", M & msk, b_dout);
      chk("ab flag after read", 36'h1, 36'(ab_full_n));
      b_op(1'b1, 1'b1, '0);
      chk("ab mail reread", M & msk, b_dout);
      b_op(1'b0, 1'b1, ~M);
      chk("ba flag after write", 36'h0, 36'(ba_full_n));
      a_op(1'b0, 1'b1, '0);
      chk("ba mail at a", ~M & msk, a_dout);
      chk("ba flag after read", 36'h1, 36'(ba_full_n));
      @(posedge core_clk);
      a_mb <= 1'b0;
      #1;
      chk("a queue output", a_fifo, a_dout);
   endtask
   task automatic t_read();
      @(posedge core_clk);
      feed_word <= W;
      feed_push <= 1'b1;
      @(posedge core_clk);
      feed_push <= 1'b0;
      for (int k = 0; k < nparts; k++) begin
         b_op(1'b1, 1'b0, '0);
         chk("b read part", part(k), b_dout);
      end
   endtask
   task automatic t_write();
      int n0;
      n0 = i_model.got.size();
      @(posedge core_clk);
      stall <= 1'b1;
      b_op(1'b0, 1'b0, ~W);
      @(posedge core_clk);
      stall <= 1'b0;
      for (int k = 0; k < nparts; k++) begin
         if (k == nparts - 1) chk("early push", 36'(n0), 36'(i_model.got.size()));
         b_op(1'b0, 1'b0, part(k) | ~msk);
      end
      repeat (2) @(posedge core_clk);
      #1;
      chk("push count", 36'(n0 + 1), 36'(i_model.got.size()));
      chk("b written word", W, i_model.got[$]);
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      n_fail = 0;
      n_compared = 0;
      {nrst, bm, sz, be, stall, feed_push} = 6'h00;
      {a_cs_n, a_wr, a_gate, a_mb, b_cs_n, b_rd, b_gate, b_mb} = 8'h88;
      {a_din, b_din, feed_word} = '0;
      a_fifo = 36'h0F0F0F0F0;
      for (int i = 0; i < 5; i++) begin
         do_reset(BMS[i], SZS[i], BES[i]);
         t_mail();
         t_read();
         t_write();
         $display("test done for mode %0d", i);
      end
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      give_verdict();
   end
endmodule
